// ---- rtl/mic_pkg.sv ----
/*
  Shared constants and types of the interrupt controller: register
  offsets, field positions, reset values, vector numbering, carriers.
  Assumes an 8-bit register port and a core with a PC_W-bit counter.
*/
package mic_pkg;

  // ==========================================================
  // widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int NUM_VEC = 7;
  localparam int VEC_W = 3;

  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_GLOBAL_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_GROUP_CTRL = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_UART1_SPI = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_TIMER_GROUP0 = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_TIMER_GROUP1 = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_EEPROM_LOWVOLT = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_EDGE_SELECT = 4'h6;

  // ==========================================================
  // field positions
  localparam int FLAG_LSB = 4;
  localparam int EN_LSB = 0;
  localparam int GLB_EN_BIT = 0;
  localparam int EXT_EN_LSB = 1;
  localparam int EXT_FLAG_LSB = 4;
  localparam int EDGE_LSB = 0;

  // ==========================================================
  // reset values
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;

  // ==========================================================
  // edge select codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ==========================================================
  // vector numbers, lower number wins
  localparam logic [VEC_W-1:0] VEC_EXT0 = 3'h0;
  localparam logic [VEC_W-1:0] VEC_EXT1 = 3'h1;
  localparam logic [VEC_W-1:0] VEC_GRP0 = 3'h2;
  localparam logic [VEC_W-1:0] VEC_GRP1 = 3'h3;
  localparam logic [VEC_W-1:0] VEC_GRP2 = 3'h4;
  localparam logic [VEC_W-1:0] VEC_SPI = 3'h5;
  localparam logic [VEC_W-1:0] VEC_UART1 = 3'h6;
  localparam logic [PC_W-1:0] VEC_BASE = 13'h0004;
  localparam logic [PC_W-1:0] VEC_STEP = 13'h0004;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mic_bus_req_t;

  typedef struct packed {
    logic uart1;
    logic spi;
    logic [3:0] tg0;
    logic [3:0] tg1;
    logic ee_done;
    logic lv_supply;
    logic lv_pin;
  } mic_evt_t;

  typedef struct packed {
    logic take;
    logic [VEC_W-1:0] idx;
    logic [PC_W-1:0] vec_addr;
    logic [PC_W-1:0] push_pc;
  } mic_vec_t;

  typedef struct packed {
    logic glb_en;
    logic [1:0] ext_en;
    logic [1:0] ext_flag;
    logic [3:0] edge_sel;
    logic [2:0] grp_en;
    logic [2:0] grp_flag;
    logic [1:0] us_flag;
    logic [1:0] us_en;
    logic [3:0] tg0_flag;
    logic [3:0] tg0_en;
    logic [3:0] tg1_flag;
    logic [3:0] tg1_en;
    logic [1:0] el_flag;
    logic [1:0] el_en;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] pin_prev;
    logic [DATA_W-1:0] rdata;
    mic_vec_t vec;
    logic pop;
    logic wake;
  } mic_state_t;

endpackage

// ---- rtl/mic_intc.sv ----
/*
  Interrupt request and enable logic of an 8-bit microcontroller core:
  flags, enables, external edge pins, group flags, arbitration, vector
  hand-off and wake-up.
  Assumes peripherals give one-cycle event pulses on clk_i, the core
  marks instruction boundaries and does the stack push/pop itself.
*/
`timescale 1ns/10ps
`default_nettype none

module mic_intc #(
  parameter logic [mic_pkg::PC_W-1:0] VEC_BASE = mic_pkg::VEC_BASE,
  parameter logic [mic_pkg::PC_W-1:0] VEC_STEP = mic_pkg::VEC_STEP
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire mic_pkg::mic_bus_req_t bus_i,
  output logic [mic_pkg::DATA_W-1:0] rdata_o,
  // peripheral events
  input wire mic_pkg::mic_evt_t evt_i,
  // external pins and their port setup
  input wire logic [1:0] ext_pin_i,
  input wire logic [1:0] pin_func_sel_i,
  input wire logic [1:0] pin_is_input_i,
  // core sequencer and stack
  input wire logic boundary_i,
  input wire logic stack_full_i,
  input wire logic [mic_pkg::PC_W-1:0] pc_next_i,
  input wire logic return_from_irq_i,
  input wire logic sleep_i,
  output mic_pkg::mic_vec_t vec_o,
  output logic stack_pop_o,
  output logic wake_o,
  output logic global_irq_enable_o
);

  // ==========================================================
  // elaboration checks
  localparam int unsigned TOP_ADDR = int'(VEC_BASE) + (mic_pkg::NUM_VEC - 1) * int'(VEC_STEP);

  // refused at elaboration, so a bad table never reaches the core
  if (VEC_STEP == '0 || TOP_ADDR >= (1 << mic_pkg::PC_W)) begin : g_vec_chk
    $error("vector table does not fit the program counter");
  end

  // ==========================================================
  // priority encoder
  function automatic logic [mic_pkg::VEC_W-1:0] pick_vec(input logic [mic_pkg::NUM_VEC-1:0] req);
    logic [mic_pkg::VEC_W-1:0] idx;
    idx = '0;
    for (int i = mic_pkg::NUM_VEC - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = i[mic_pkg::VEC_W-1:0];
      end
    end
    return idx;
  endfunction

  mic_pkg::mic_state_t q, n;

  // ==========================================================
  // next state
  logic [1:0] ext_hit;
  logic [1:0] us_set;
  logic [3:0] tg0_set;
  logic [3:0] tg1_set;
  logic [1:0] el_set;
  logic [2:0] grp_set;
  logic [mic_pkg::NUM_VEC-1:0] req;
  logic take;
  logic [mic_pkg::VEC_W-1:0] win;
  logic wr_en;
  logic [mic_pkg::DATA_W-1:0] rd_mux;

  always_comb begin
    n = q;
    wr_en = bus_i.wr;

    // pin synchroniser; only pin_s2 onward feeds logic
    n.pin_s1 = ext_pin_i;
    n.pin_s2 = q.pin_s1;
    n.pin_prev = q.pin_s2;

    for (int p = 0; p < 2; p++) begin
      logic rise;
      logic fall;
      logic armed;
      rise = q.pin_s2[p] & ~q.pin_prev[p];
      fall = ~q.pin_s2[p] & q.pin_prev[p];
      armed = q.ext_en[p] & pin_func_sel_i[p] & pin_is_input_i[p];
      case (q.edge_sel[2*p +: 2])
        mic_pkg::EDGE_RISE: ext_hit[p] = armed & rise;
        mic_pkg::EDGE_FALL: ext_hit[p] = armed & fall;
        mic_pkg::EDGE_BOTH: ext_hit[p] = armed & (rise | fall);
        default: ext_hit[p] = 1'b0;
      endcase
    end

    // event pulses become flags one clock later
    us_set = {evt_i.uart1, evt_i.spi};
    tg0_set = evt_i.tg0;
    tg1_set = evt_i.tg1;
    el_set = {evt_i.ee_done, evt_i.lv_supply | evt_i.lv_pin};
    // member sets only reach the group when the member is enabled
    grp_set[0] = |(tg0_set & q.tg0_en);
    grp_set[1] = |(tg1_set & q.tg1_en);
    grp_set[2] = |(el_set & q.el_en);

    // requests in priority order; flags stay even when not taken
    req[mic_pkg::VEC_EXT0] = q.ext_flag[0] & q.ext_en[0];
    req[mic_pkg::VEC_EXT1] = q.ext_flag[1] & q.ext_en[1];
    req[mic_pkg::VEC_GRP0] = q.grp_flag[0] & q.grp_en[0];
    req[mic_pkg::VEC_GRP1] = q.grp_flag[1] & q.grp_en[1];
    req[mic_pkg::VEC_GRP2] = q.grp_flag[2] & q.grp_en[2];
    req[mic_pkg::VEC_SPI] = q.us_flag[0] & q.us_en[0];
    req[mic_pkg::VEC_UART1] = q.us_flag[1] & q.us_en[1];
    win = pick_vec(req);
    take = boundary_i & q.glb_en & ~stack_full_i & (|req);

    // software writes first, then service clears, then hardware sets
    if (wr_en) begin
      case (bus_i.addr)
        mic_pkg::ADDR_GLOBAL_CTRL: begin
          n.glb_en = bus_i.wdata[mic_pkg::GLB_EN_BIT];
          n.ext_en = bus_i.wdata[mic_pkg::EXT_EN_LSB +: 2];
          n.ext_flag = bus_i.wdata[mic_pkg::EXT_FLAG_LSB +: 2];
        end
        mic_pkg::ADDR_GROUP_CTRL: begin
          n.grp_en = bus_i.wdata[mic_pkg::EN_LSB +: 3];
          n.grp_flag = bus_i.wdata[mic_pkg::FLAG_LSB +: 3];
        end
        mic_pkg::ADDR_UART1_SPI: begin
          n.us_en = bus_i.wdata[mic_pkg::EN_LSB +: 2];
          n.us_flag = bus_i.wdata[mic_pkg::FLAG_LSB +: 2];
        end
        mic_pkg::ADDR_TIMER_GROUP0: begin
          n.tg0_en = bus_i.wdata[mic_pkg::EN_LSB +: 4];
          n.tg0_flag = bus_i.wdata[mic_pkg::FLAG_LSB +: 4];
        end
        mic_pkg::ADDR_TIMER_GROUP1: begin
          n.tg1_en = bus_i.wdata[mic_pkg::EN_LSB +: 4];
          n.tg1_flag = bus_i.wdata[mic_pkg::FLAG_LSB +: 4];
        end
        mic_pkg::ADDR_EEPROM_LOWVOLT: begin
          n.el_en = bus_i.wdata[mic_pkg::EN_LSB +: 2];
          n.el_flag = bus_i.wdata[mic_pkg::FLAG_LSB +: 2];
        end
        mic_pkg::ADDR_EDGE_SELECT: begin
          n.edge_sel = bus_i.wdata[mic_pkg::EDGE_LSB +: 4];
        end
        default: begin
        end
      endcase
    end

    if (take) begin
      n.glb_en = 1'b0;
      case (win)
        mic_pkg::VEC_EXT0: n.ext_flag[0] = 1'b0;
        mic_pkg::VEC_EXT1: n.ext_flag[1] = 1'b0;
        // group service leaves the member flags to software
        mic_pkg::VEC_GRP0: n.grp_flag[0] = 1'b0;
        mic_pkg::VEC_GRP1: n.grp_flag[1] = 1'b0;
        mic_pkg::VEC_GRP2: n.grp_flag[2] = 1'b0;
        mic_pkg::VEC_SPI: n.us_flag[0] = 1'b0;
        mic_pkg::VEC_UART1: n.us_flag[1] = 1'b0;
        default: begin
        end
      endcase
    end

    n.ext_flag = n.ext_flag | ext_hit;
    n.us_flag = n.us_flag | us_set;
    n.tg0_flag = n.tg0_flag | tg0_set;
    n.tg1_flag = n.tg1_flag | tg1_set;
    n.el_flag = n.el_flag | el_set;
    n.grp_flag = n.grp_flag | grp_set;

    // only a flag going from clear to set wakes the core
    n.wake = sleep_i & (|(ext_hit & ~q.ext_flag) | |(us_set & ~q.us_flag)
      | |(tg0_set & ~q.tg0_flag) | |(tg1_set & ~q.tg1_flag) | |(el_set & ~q.el_flag)
      | |(grp_set & ~q.grp_flag));

    // core hand-off: push the next pc and jump to the vector
    n.vec.take = take;
    n.vec.idx = take ? win : q.vec.idx;
    n.vec.push_pc = take ? pc_next_i : q.vec.push_pc;
    n.vec.vec_addr = take ? (VEC_BASE + mic_pkg::PC_W'(win) * VEC_STEP) : q.vec.vec_addr;
    n.pop = return_from_irq_i;

    // read data
    case (bus_i.addr)
      mic_pkg::ADDR_GLOBAL_CTRL: rd_mux = {2'h0, q.ext_flag, 1'b0, q.ext_en, q.glb_en};
      mic_pkg::ADDR_GROUP_CTRL: rd_mux = {1'b0, q.grp_flag, 1'b0, q.grp_en};
      mic_pkg::ADDR_UART1_SPI: rd_mux = {2'h0, q.us_flag, 2'h0, q.us_en};
      mic_pkg::ADDR_TIMER_GROUP0: rd_mux = {q.tg0_flag, q.tg0_en};
      mic_pkg::ADDR_TIMER_GROUP1: rd_mux = {q.tg1_flag, q.tg1_en};
      mic_pkg::ADDR_EEPROM_LOWVOLT: rd_mux = {2'h0, q.el_flag, 2'h0, q.el_en};
      mic_pkg::ADDR_EDGE_SELECT: rd_mux = {4'h0, q.edge_sel};
      default: rd_mux = mic_pkg::RDATA_IDLE;
    endcase
    n.rdata = bus_i.rd ? rd_mux : mic_pkg::RDATA_IDLE;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // outputs
  assign rdata_o = q.rdata;
  assign vec_o = q.vec;
  assign stack_pop_o = q.pop;
  assign wake_o = q.wake;
  assign global_irq_enable_o = q.glb_en;

endmodule

`default_nettype wire

// ---- verif/mic_intc_props.sv ----
/*
  Concurrent checks on the interrupt controller ports, bound into mic_intc.
  Assumes one clock domain with rst_i as asynchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
module mic_intc_props #(
  parameter logic [mic_pkg::PC_W-1:0] VEC_BASE = mic_pkg::VEC_BASE,
  parameter logic [mic_pkg::PC_W-1:0] VEC_STEP = mic_pkg::VEC_STEP
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched ports
  input wire mic_pkg::mic_bus_req_t bus_i,
  input wire logic [mic_pkg::DATA_W-1:0] rdata_o,
  input wire logic boundary_i,
  input wire logic stack_full_i,
  input wire logic [mic_pkg::PC_W-1:0] pc_next_i,
  input wire logic return_from_irq_i,
  input wire logic sleep_i,
  input wire mic_pkg::mic_vec_t vec_o,
  input wire logic stack_pop_o,
  input wire logic wake_o,
  input wire logic global_irq_enable_o
);
  // ==========
  // checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_blocked;
    !global_irq_enable_o || !boundary_i || stack_full_i;
  endsequence
  sequence s_rd_mixed;
    bus_i.rd && (bus_i.addr == mic_pkg::ADDR_UART1_SPI || bus_i.addr == mic_pkg::ADDR_EEPROM_LOWVOLT);
  endsequence
  take_gate_a: assert property (not (s_blocked ##1 vec_o.take))
    else $error("take while blocked");
  take_drop_a: assert property (vec_o.take |-> !global_irq_enable_o)
    else $error("global enable kept on take");
  vec_map_a: assert property (vec_o.take |-> vec_o.vec_addr == VEC_BASE + VEC_STEP * 13'(vec_o.idx))
    else $error("vector address mismatch");
  push_pc_a: assert property (vec_o.take |-> vec_o.push_pc == $past(pc_next_i))
    else $error("pushed pc mismatch");
  take_once_a: assert property (vec_o.take |=> !vec_o.take)
    else $error("second take in a row");
  ret_pop_a: assert property (return_from_irq_i |=> stack_pop_o)
    else $error("no pop after return");
  wake_sleep_a: assert property (wake_o |-> $past(sleep_i))
    else $error("wake outside sleep");
  resv_zero_a: assert property (s_rd_mixed |=> rdata_o[7:6] == 2'h0 && rdata_o[3:2] == 2'h0)
    else $error("reserved bits not zero");
  glb_write_a: assert property (bus_i.wr && bus_i.addr == mic_pkg::ADDR_GLOBAL_CTRL && !boundary_i
    |=> global_irq_enable_o == $past(bus_i.wdata[0]))
    else $error("global enable write lost");
endmodule
bind mic_intc mic_intc_props #(.VEC_BASE(VEC_BASE), .VEC_STEP(VEC_STEP)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o), .boundary_i(boundary_i),
  .stack_full_i(stack_full_i), .pc_next_i(pc_next_i), .return_from_irq_i(return_from_irq_i),
  .sleep_i(sleep_i), .vec_o(vec_o), .stack_pop_o(stack_pop_o), .wake_o(wake_o),
  .global_irq_enable_o(global_irq_enable_o));
`default_nettype wire

// ---- verif/mic_core_model.sv ----
/*
  Core sequencer and stack model facing the interrupt controller.
  Assumes the bench steers boundaries and asks for returns.
*/
`timescale 1ns/10ps
`default_nettype none
module mic_core_model #(
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // controller and bench
  input wire mic_pkg::mic_vec_t vec_i,
  input wire logic pop_i,
  input wire logic ret_req_i,
  input wire logic bnd_en_i,
  input wire logic slow_i,
  // to the controller, pc_o to the bench
  output logic boundary_o,
  output logic stack_full_o,
  output logic [mic_pkg::PC_W-1:0] pc_next_o,
  output logic ret_o,
  output logic [mic_pkg::PC_W-1:0] pc_o
);
  // ==========
  // stack
  logic [mic_pkg::PC_W-1:0] stk_q [DEPTH];
  int sp_q;
  logic [1:0] cnt_q;
  assign pc_next_o = pc_o + 13'h0001;
  assign stack_full_o = sp_q == DEPTH;
  // slow core: boundary only every fourth cycle
  assign boundary_o = bnd_en_i && (!slow_i || cnt_q == 2'h0);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sp_q <= 0;
      pc_o <= 13'h0100;
      cnt_q <= 2'h0;
      ret_o <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      ret_o <= ret_req_i;
      if (vec_i.take) begin
        stk_q[sp_q] <= vec_i.push_pc;
        sp_q <= sp_q + 1;
        pc_o <= vec_i.vec_addr;
      end else if (pop_i) begin
        sp_q <= sp_q - 1;
        pc_o <= stk_q[sp_q-1];
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
/*
  Self-checking bench of the interrupt controller with a core model.
  Assumes the package constants and one 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ==========
  // signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  mic_pkg::mic_bus_req_t bus = '0;
  mic_pkg::mic_evt_t evt = '0;
  mic_pkg::mic_vec_t vec;
  logic [1:0] pin = 2'h0;
  logic [1:0] fsel = 2'h3;
  logic [1:0] pin_in = 2'h3;
  logic sleep = 1'b0;
  logic bnd_en = 1'b0;
  logic slow = 1'b0;
  logic ret_req = 1'b0;
  logic bnd, sfull, ret, pop, wake, glb;
  logic [12:0] pcn, pc;
  logic [7:0] rdata;
  int n_errors = 0;
  int cmp_count = 0;
  int takes = 0;
  int wakes = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  mic_intc uut (.clk_i(clk), .rst_i(rst), .bus_i(bus), .rdata_o(rdata), .evt_i(evt), .ext_pin_i(pin),
    .pin_func_sel_i(fsel), .pin_is_input_i(pin_in), .boundary_i(bnd), .stack_full_i(sfull),
    .pc_next_i(pcn), .return_from_irq_i(ret), .sleep_i(sleep), .vec_o(vec), .stack_pop_o(pop),
    .wake_o(wake), .global_irq_enable_o(glb));
  mic_core_model core (.clk_i(clk), .rst_i(rst), .vec_i(vec), .pop_i(pop), .ret_req_i(ret_req),
    .bnd_en_i(bnd_en), .slow_i(slow), .boundary_o(bnd), .stack_full_o(sfull), .pc_next_o(pcn),
    .ret_o(ret), .pc_o(pc));
  always @(posedge clk) begin
    cyc++;
    if (vec.take === 1'b1) takes++;
    if (wake === 1'b1) wakes++;
    if (cyc == 3000) begin
      n_errors++;
      summarize();
    end
  end
  // ==========
  // tasks
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    bus <= '0;
    #1;
    chk({5'h00, rdata}, {5'h00, e});
  endtask
  task automatic ev(input mic_pkg::mic_evt_t e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
    #1;
  endtask
  task automatic ret_once;
    @(posedge clk);
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    cy(3);
  endtask
  task automatic svc(input logic [2:0] idx, input logic [7:0] gw = 8'h01);
    logic [12:0] saved;
    saved = pc + 13'h0001;
    wr(4'h0, gw);
    cy(3);
    chk({10'h000, vec.idx}, {10'h000, idx});
    chk(vec.push_pc, saved);
    chk(pc, mic_pkg::VEC_BASE + mic_pkg::VEC_STEP * {10'h000, idx});
    ret_once();
    chk(pc, saved);
  endtask
  task automatic t_regs;
    for (int a = 0; a < 16; a++) rd(a[3:0], 8'h00);
    for (int a = 2; a < 6; a++) begin
      wr(a[3:0], 8'hFF);
      rd(a[3:0], (a == 2 || a == 5) ? 8'h33 : 8'hFF);
      wr(a[3:0], 8'h00);
    end
    $display("regs done");
  endtask
  task automatic t_ext;
    for (int c = 0; c < 4; c++) begin
      wr(4'h6, {4'h0, c[1:0], c[1:0]});
      wr(4'h0, 8'h06);
      pin <= 2'h3;
      cy(4);
      rd(4'h0, c[0] ? 8'h36 : 8'h06);
      wr(4'h0, 8'h06);
      pin <= 2'h0;
      cy(4);
      rd(4'h0, c[1] ? 8'h36 : 8'h06);
    end
    wr(4'h0, 8'h06);
    fsel <= 2'h1;
    pin_in <= 2'h2;
    pin <= 2'h3;
    cy(5);
    rd(4'h0, 8'h06);
    wr(4'h0, 8'h00);
    $display("ext done");
  endtask
  task automatic t_wake;
    @(posedge clk);
    sleep <= 1'b1;
    ev('{uart1: 1'b1, default: '0});
    cy(2);
    chk(wakes[12:0], 13'h0001);
    ev('{uart1: 1'b1, default: '0});
    cy(2);
    chk(wakes[12:0], 13'h0001);
    @(posedge clk);
    sleep <= 1'b0;
    wr(4'h2, 8'h00);
    $display("wake done");
  endtask
  task automatic t_spi;
    wr(4'h2, 8'h01);
    bnd_en <= 1'b1;
    ev('{spi: 1'b1, default: '0});
    cy(3);
    chk(takes[12:0], 13'h0000);
    rd(4'h2, 8'h11);
    svc(mic_pkg::VEC_SPI);
    for (int i = 0; i < 3; i++) begin
      ev('{spi: 1'b1, default: '0});
      wr(4'h0, 8'h01);
      cy(5);
    end
    chk(takes[12:0], 13'h0003);
    chk({12'h000, glb}, 13'h0001);
    slow <= 1'b1;
    ret_once();
    cy(8);
    chk(takes[12:0], 13'h0004);
    ret_once();
    ret_once();
    slow <= 1'b0;
    $display("spi done");
  endtask
  task automatic t_prio;
    wr(4'h2, 8'h03);
    wr(4'h3, 8'h08);
    wr(4'h5, 8'h02);
    wr(4'h4, 8'h01);
    wr(4'h1, 8'h07);
    ev('{uart1: 1'b1, spi: 1'b1, tg0: 4'h8, tg1: 4'h1, ee_done: 1'b1, default: '0});
    rd(4'h1, 8'h77);
    svc(mic_pkg::VEC_GRP0);
    rd(4'h3, 8'h88);
    svc(mic_pkg::VEC_GRP1);
    rd(4'h4, 8'h11);
    svc(mic_pkg::VEC_GRP2);
    rd(4'h5, 8'h22);
    rd(4'h1, 8'h07);
    svc(mic_pkg::VEC_SPI);
    svc(mic_pkg::VEC_UART1);
    $display("prio done");
  endtask
  task automatic t_lv;
    int t0;
    t0 = takes;
    wr(4'h5, 8'h01);
    wr(4'h1, 8'h00);
    ev('{lv_pin: 1'b1, default: '0});
    wr(4'h0, 8'h01);
    cy(4);
    chk(takes[12:0], t0[12:0]);
    rd(4'h5, 8'h11);
    wr(4'h0, 8'h00);
    rd(4'h1, 8'h40);
    // group write carries the flag too, so keep it pending
    wr(4'h1, 8'h44);
    svc(mic_pkg::VEC_GRP2);
    rd(4'h5, 8'h11);
    rd(4'h1, 8'h04);
    wr(4'h5, 8'h01);
    ev('{lv_supply: 1'b1, default: '0});
    rd(4'h5, 8'h11);
    $display("lowvolt done");
  endtask
  task automatic t_ext_svc;
    wr(4'h6, 8'h01);
    fsel <= 2'h3;
    pin_in <= 2'h3;
    pin <= 2'h0;
    wr(4'h0, 8'h02);
    cy(4);
    @(posedge clk);
    pin <= 2'h1;
    cy(4);
    rd(4'h0, 8'h12);
    svc(mic_pkg::VEC_EXT0, 8'h13);
    rd(4'h0, 8'h02);
    wr(4'h0, 8'h00);
    $display("ext service done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_ext();
    t_wake();
    t_spi();
    t_prio();
    t_lv();
    t_ext_svc();
    summarize();
  end
endmodule
`default_nettype wire
